// File: verilog/swr_slave.sv
`timescale 1ns/1ps
module swr_slave import swr_pkg::*; #(
    parameter logic [63:0] ROM_ID       = 64'h5A00_0000_0000_0001,
    parameter int          TICK_DIV     = TICK_CYCLES,
    parameter logic [11:0] INT_PULSE_US = INT_PULSE_US_DEF
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // Open-drain bus line
    input  wire logic                  line_in,
    output logic                       line_out,
    output logic                       line_oe_n,
    // Alarm sources
    input  wire logic [NUM_ALARMS-1:0] alarm_event,
    input  wire logic [NUM_ALARMS-1:0] int_enable,
    // Status byte read
    input  wire logic                  status_rd,
    input  wire logic [11:0]           status_rd_addr,
    output logic [7:0]                 alarm_flag_status,
    // Function layer
    output logic                       func_active,
    output logic                       int_pending
);
    // The ROM_ID default is arbitrary.

    // ==========================================================
    // Reset release and line sampling
    logic                  rst_s0_q, rst_s1_q, rst_sync_n;
    logic                  line_s, line_prev_q, fall, tick;
    logic [11:0]           low_us_q, st_us_q, slot_us_q;
    swr_state_type         state_q, state_d;
    logic [5:0]            bit_idx_q;
    logic [1:0]            step_q;
    logic [7:0]            cmd_q, cmd_byte;
    logic                  slot_act_q, slot_evt, rd0_q, rd0_d, line_oe_n_q;
    logic [NUM_ALARMS-1:0] flags_q, flags_d;
    logic                  flag_clr, int_cond, int_new, signalled_q, armed_q, self_q, post_int_q;
    logic                  rst_det, bit_state, tx_now, tx_bit, rom_bit, cmd_done;
    logic                  func_active_q, int_pending_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s0_q <= 1'b0;
            rst_s1_q <= 1'b0;
        end else begin
            rst_s0_q <= 1'b1;
            rst_s1_q <= rst_s0_q;
        end
    end
    assign rst_sync_n = rst_s1_q;

    swr_sync #(.RESET_VAL(1'b1)) u_line_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_sync_n),
        .d       (line_in),
        .q       (line_s)
    );

    swr_us_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_sync_n),
        .tick    (tick)
    );

    assign fall = line_prev_q & ~line_s;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            line_prev_q <= 1'b1;
            low_us_q    <= '0;
        end else begin
            line_prev_q <= line_s;
            if (line_s) begin
                low_us_q <= '0;
            end else if (tick && low_us_q != US_SAT) begin
                low_us_q <= low_us_q + 12'h001;
            end
        end
    end

    // Long low not of our own making
    assign rst_det = tick && !line_s && line_oe_n_q && low_us_q == RST_DETECT_US &&
                     state_q != ST_RST_LOW && state_q != ST_INT_PULSE;

    // ==========================================================
    // Alarm flags and interrupt condition
    assign flag_clr = status_rd && status_rd_addr == STATUS_ADDR;
    assign flags_d  = (flags_q & ~{NUM_ALARMS{flag_clr}}) | alarm_event;
    assign int_cond = |(flags_q & int_enable);
    assign int_new  = int_cond && !signalled_q;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_q       <= ALARM_FLAGS_RST[NUM_ALARMS-1:0];
            int_pending_q <= 1'b0;
        end else begin
            flags_q       <= flags_d;
            int_pending_q <= |(flags_d & int_enable);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            signalled_q <= 1'b0;
        end else if (!int_cond) begin
            signalled_q <= 1'b0;
        end else if (state_d == ST_INT_PULSE && state_q != ST_INT_PULSE) begin
            signalled_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            armed_q <= 1'b0;
        end else if (fall) begin
            armed_q <= 1'b0;
        end else if (state_q == ST_PD_LOW && state_d == ST_ROM_CMD) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            self_q     <= 1'b0;
            post_int_q <= 1'b0;
        end else begin
            if (state_d == ST_FUNC) begin
                self_q <= 1'b1;
            end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
                self_q <= 1'b0;
            end
            if (rst_det) begin
                post_int_q <= 1'b0;
            end else if (state_q == ST_INT_PULSE && state_d != ST_INT_PULSE) begin
                post_int_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Bit slots
    assign bit_state = state_q == ST_ROM_CMD || state_q == ST_ROM_READ ||
                       state_q == ST_ROM_MATCH || state_q == ST_SEARCH;
    assign rom_bit   = ROM_ID[bit_idx_q];
    assign tx_now    = state_q == ST_ROM_READ || (state_q == ST_SEARCH && step_q != 2'h2);
    assign tx_bit    = (state_q == ST_SEARCH && step_q == 2'h1) ? ~rom_bit : rom_bit;
    assign slot_evt  = slot_act_q && tick && slot_us_q == WRITE_SAMPLE_US;
    assign cmd_byte  = {line_s, cmd_q[7:1]};
    assign cmd_done  = state_q == ST_ROM_CMD && slot_evt && bit_idx_q[2:0] == 3'h7;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            slot_act_q <= 1'b0;
            slot_us_q  <= '0;
        end else if (fall && bit_state) begin
            slot_act_q <= 1'b1;
            slot_us_q  <= '0;
        end else if (slot_evt || !bit_state) begin
            slot_act_q <= 1'b0;
        end else if (tick && slot_act_q) begin
            slot_us_q <= slot_us_q + 12'h001;
        end
    end

    always_comb begin
        rd0_d = rd0_q;
        if (fall && bit_state && tx_now && !tx_bit) begin
            rd0_d = 1'b1;
        end else if (!bit_state || (tick && slot_us_q == READ_HOLD_US)) begin
            rd0_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_idx_q <= '0;
            step_q    <= '0;
            cmd_q     <= '0;
        end else if (state_q != state_d) begin
            bit_idx_q <= '0;
            step_q    <= '0;
        end else if (slot_evt) begin
            if (state_q == ST_ROM_CMD) begin
                cmd_q     <= cmd_byte;
                bit_idx_q <= bit_idx_q + 6'h01;
            end else if (state_q == ST_SEARCH && step_q != 2'h2) begin
                step_q <= step_q + 2'h1;
            end else begin
                step_q    <= '0;
                bit_idx_q <= bit_idx_q + 6'h01;
            end
        end
    end

    // ==========================================================
    // Main sequencer
    always_comb begin
        state_d = state_q;
        if (rst_det) begin
            state_d = (int_cond && !self_q) ? ST_INT_PULSE : ST_RST_LOW;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (armed_q && line_s && int_new) state_d = ST_INT_PULSE;
                end
                ST_RST_LOW: begin
                    if (int_new) begin
                        state_d = ST_INT_PULSE;
                    end else if (line_s && line_oe_n_q) begin
                        state_d = ST_PD_WAIT;
                    end
                end
                ST_PD_WAIT: begin
                    if (tick && st_us_q == PRES_WAIT_US) state_d = ST_PD_LOW;
                end
                ST_PD_LOW: begin
                    if (tick && st_us_q == PRES_LOW_US) begin
                        if (int_cond && !post_int_q && (!signalled_q || self_q)) begin
                            state_d = ST_INT_PULSE;
                        end else begin
                            state_d = ST_ROM_CMD;
                        end
                    end
                end
                ST_INT_PULSE: begin
                    if (tick && st_us_q == INT_PULSE_US) state_d = ST_RST_LOW;
                end
                ST_ROM_CMD: begin
                    if (armed_q && line_s && int_new) begin
                        state_d = ST_INT_PULSE;
                    end else if (cmd_done) begin
                        unique case (cmd_byte)
                            CMD_READ_ID:      state_d = ST_ROM_READ;
                            CMD_MATCH_ID:     state_d = ST_ROM_MATCH;
                            CMD_SKIP_ID:      state_d = ST_FUNC;
                            CMD_SEARCH:       state_d = ST_SEARCH;
                            CMD_ALARM_SEARCH: state_d = int_cond ? ST_SEARCH : ST_IDLE;
                            default:          state_d = ST_IDLE;
                        endcase
                    end
                end
                ST_ROM_READ: begin
                    if (slot_evt && bit_idx_q == ID_LAST_BIT) state_d = ST_FUNC;
                end
                ST_ROM_MATCH: begin
                    if (slot_evt) begin
                        if (line_s != rom_bit) begin
                            state_d = ST_IDLE;
                        end else if (bit_idx_q == ID_LAST_BIT) begin
                            state_d = ST_FUNC;
                        end
                    end
                end
                ST_SEARCH: begin
                    if (slot_evt && step_q == 2'h2) begin
                        if (line_s != rom_bit) begin
                            state_d = ST_IDLE;
                        end else if (bit_idx_q == ID_LAST_BIT) begin
                            state_d = ST_FUNC;
                        end
                    end
                end
                ST_FUNC: state_d = ST_FUNC;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= ST_PD_WAIT;
            st_us_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != state_d) begin
                st_us_q <= '0;
            end else if (tick && st_us_q != US_SAT) begin
                st_us_q <= st_us_q + 12'h001;
            end
        end
    end

    // ==========================================================
    // Line drive and outputs
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd0_q         <= 1'b0;
            line_oe_n_q   <= 1'b1;
            func_active_q <= 1'b0;
        end else begin
            rd0_q         <= rd0_d;
            line_oe_n_q   <= ~(state_d == ST_INT_PULSE || state_d == ST_PD_LOW || rd0_d);
            func_active_q <= state_d == ST_FUNC;
        end
    end

    assign line_out          = 1'b0;
    assign line_oe_n         = line_oe_n_q;
    assign func_active       = func_active_q;
    assign int_pending       = int_pending_q;
    assign alarm_flag_status = {{(8 - NUM_ALARMS){1'b0}}, flags_q};

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    sequence s_zero_slot;
        fall && bit_state && tx_now && !tx_bit;
    endsequence
    sequence s_zero_hold;
        !line_oe_n_q [*8];
    endsequence

    a_skip_selects: assert property (cmd_done && !rst_det && cmd_byte == CMD_SKIP_ID |=> state_q == ST_FUNC
    ) else $error("skip command did not select function phase");
    a_search_compl: assert property (fall && state_q == ST_SEARCH && step_q == 2'h1 && rom_bit
        |=> !line_oe_n_q) else $error("complement bit not driven low");
    a_alarm_gate: assert property (cmd_done && !rst_det && cmd_byte == CMD_ALARM_SEARCH && !int_cond
        |=> state_q == ST_IDLE) else $error("alarm search joined without interrupt");
    a_pres_wait: assert property (state_q == ST_PD_WAIT && state_d == ST_PD_LOW
        |-> st_us_q == PRES_WAIT_US ##1 !line_oe_n_q) else $error("presence wait wrong");
    a_pres_low: assert property (state_q == ST_PD_LOW && state_d != ST_PD_LOW
        |-> st_us_q == PRES_LOW_US) else $error("presence low length wrong");
    a_read_zero: assert property (s_zero_slot |=> s_zero_hold) else $error("read zero not held");
    a_read_one: assert property (fall && bit_state && tx_now && tx_bit && !rd0_q
        |=> line_oe_n_q) else $error("read one disturbed the line");
    a_flag_clear: assert property (flag_clr && alarm_event == '0 |=> alarm_flag_status == 8'h00
    ) else $error("status read did not clear flags");
    a_flag_set: assert property (alarm_event[0] |=> alarm_flag_status[0]) else $error("alarm flag lost");
    a_fall_disarm: assert property (fall |=> !armed_q) else $error("fall did not disarm");
    a_int_len: assert property (state_q == ST_INT_PULSE && state_d != ST_INT_PULSE
        |-> st_us_q == INT_PULSE_US) else $error("interrupt pulse length wrong");
    a_stretch: assert property (rst_det && int_cond && !self_q |=> state_q == ST_INT_PULSE
        ##1 !line_oe_n_q) else $error("reset not stretched");
    a_postpone: assert property (state_q == ST_PD_WAIT |=> state_q != ST_INT_PULSE
    ) else $error("interrupt inside presence");
    a_search_drop: assert property (slot_evt && state_q == ST_SEARCH && step_q == 2'h2 && !rst_det &&
        line_s != rom_bit |=> state_q == ST_IDLE) else $error("search loser stayed");
endmodule

// File: pkg/swr_pkg.sv
package swr_pkg;

    // ==========================================================
    // Timing
    localparam int          CLK_FREQ_MHZ     = 250;
    localparam int          TICK_US          = 1;
    localparam int          TICK_CYCLES      = CLK_FREQ_MHZ * TICK_US;
    localparam int          US_W             = 12;
    localparam logic [11:0] RST_DETECT_US    = 12'h078;
    localparam logic [11:0] PRES_WAIT_US     = 12'h01E;
    localparam logic [11:0] PRES_LOW_US      = 12'h078;
    localparam logic [11:0] INT_PULSE_US_DEF = 12'h5DC;
    localparam logic [11:0] WRITE_SAMPLE_US  = 12'h01E;
    localparam logic [11:0] READ_HOLD_US     = 12'h01E;
    localparam logic [11:0] US_SAT           = 12'hFFF;

    // ==========================================================
    // Identity commands
    localparam logic [7:0]  CMD_READ_ID      = 8'h33;
    localparam logic [7:0]  CMD_MATCH_ID     = 8'h55;
    localparam logic [7:0]  CMD_SKIP_ID      = 8'hCC;
    localparam logic [7:0]  CMD_SEARCH       = 8'hF0;
    localparam logic [7:0]  CMD_ALARM_SEARCH = 8'hEC;
    localparam logic [5:0]  ID_LAST_BIT      = 6'h3F;

    // ==========================================================
    // Alarm flags
    localparam int          NUM_ALARMS       = 3;
    localparam logic [11:0] STATUS_ADDR      = 12'h200;
    localparam logic [7:0]  ALARM_FLAGS_RST  = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_RST_LOW   = 4'h1,
        ST_PD_WAIT   = 4'h2,
        ST_PD_LOW    = 4'h3,
        ST_INT_PULSE = 4'h4,
        ST_ROM_CMD   = 4'h5,
        ST_ROM_READ  = 4'h6,
        ST_ROM_MATCH = 4'h7,
        ST_SEARCH    = 4'h8,
        ST_FUNC      = 4'h9
    } swr_state_type;

endpackage

// File: verilog/swr_sync.sv
`timescale 1ns/1ps
module swr_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    logic q_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            q_q    <= RESET_VAL;
        end else begin
            meta_q <= d;
            q_q    <= meta_q;
        end
    end

    assign q = q_q;
endmodule

// File: verilog/swr_us_tick.sv
`timescale 1ns/1ps
module swr_us_tick #(
    parameter int DIV = 250
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // One-cycle enable each microsecond
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;
    logic          tick_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;
endmodule

// File: verif/swr_bus_master.sv
`timescale 1ns/1ps
module swr_bus_master #(
    parameter int DIV = 4
) (
    // Clock
    input  wire logic clk_sys,
    // Bus line
    input  wire logic line,
    output logic      drive_low,
    // Sampled line level
    output logic      smp_stb,
    output logic      smp_bit
);
    initial begin
        drive_low = 1'b0;
        smp_stb = 1'b0;
        smp_bit = 1'b1;
    end

    // ==========================================================
    // Timing helpers
    task automatic us(input int n);
        repeat (n * DIV) @(posedge clk_sys);
        #1;
    endtask

    task automatic peek(input int n);
        us(n);
        smp_bit = line;
        smp_stb = 1'b1;
        @(posedge clk_sys);
        #1;
        smp_stb = 1'b0;
    endtask

    // ==========================================================
    // Reset and slots, all started by the master
    task automatic bus_reset();
        drive_low = 1'b1;
        us(480);
        drive_low = 1'b0;
        peek(70);
        us(410);
        peek(0);
    endtask

    task automatic slot(input logic b, input logic rd);
        drive_low = 1'b1;
        us(rd ? 1 : (b ? 6 : 60));
        drive_low = 1'b0;
        if (rd) begin
            peek(13);
        end
        us(rd ? 56 : (b ? 64 : 10));
    endtask

    task automatic wr_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            slot(b[i], 1'b0);
        end
    endtask
endmodule

// File: verif/test_swr_slave.sv
`timescale 1ns/1ps
module test_swr_slave import swr_pkg::*; ();
    // Arbitrary identity value
    localparam logic [63:0] ID = 64'h3C5A_0F96_1E2D_7B41;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  alarm_event = 3'h0;
    logic [2:0]  int_enable = 3'h0;
    logic        status_rd = 1'b0;
    logic [11:0] status_rd_addr = 12'h000;
    logic [7:0]  alarm_flag_status;
    logic        line_out, line_oe_n, func_active, int_pending;
    logic        m_low, m_stb, m_bit;
    logic        q[$];
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    int          k;
    wire logic   line = !m_low && (line_oe_n || line_out);

    always #2 clk_sys = ~clk_sys;

    swr_slave #(.ROM_ID(ID), .TICK_DIV(4), .INT_PULSE_US(12'h0C8)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .line_in(line), .line_out(line_out),
        .line_oe_n(line_oe_n), .alarm_event(alarm_event), .int_enable(int_enable),
        .status_rd(status_rd), .status_rd_addr(status_rd_addr),
        .alarm_flag_status(alarm_flag_status), .func_active(func_active), .int_pending(int_pending));

    swr_bus_master #(.DIV(4)) master_u (
        .clk_sys(clk_sys), .line(line), .drive_low(m_low), .smp_stb(m_stb), .smp_bit(m_bit));

    // ==========================================================
    // Checking
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (m_stb === 1'b1) begin
            check(m_bit, q.pop_front());
        end
        cycles++;
        if (cycles == 80000) begin
            failures++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Stimulus helpers
    task automatic rst_seq();
        q.push_back(1'b0);
        q.push_back(1'b1);
        master_u.bus_reset();
    endtask

    task automatic rd(input logic b);
        q.push_back(b);
        master_u.slot(1'b1, 1'b1);
    endtask

    task automatic strd(input logic [11:0] a);
        status_rd = 1'b1;
        status_rd_addr = a;
        @(posedge clk_sys);
        #1 status_rd = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic alarm();
        alarm_event = 3'h1 << k;
        @(posedge clk_sys);
        #1 alarm_event = 3'h0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hA8F5E5EE));
        k = $urandom % 3;
        repeat (5) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        q.push_back(1'b0);
        master_u.peek(60);
        master_u.us(200);
        alarm_event = 3'h7;
        @(posedge clk_sys);
        #1 alarm_event = 3'h0;
        check(alarm_flag_status, 8'h07);
        strd(STATUS_ADDR);
        check(alarm_flag_status, 8'h00);
        int_enable = 3'h7;
        rst_seq();
        master_u.wr_byte(CMD_READ_ID);
        for (int i = 0; i < 64; i++) begin
            rd(ID[i]);
        end
        rst_seq();
        master_u.wr_byte(CMD_SEARCH);
        for (int i = 0; i < 5; i++) begin
            rd(ID[i]);
            rd(!ID[i]);
            master_u.slot(ID[i] ^ (i == 4), 1'b0);
        end
        rd(1'b1);
        rd(1'b1);
        rst_seq();
        master_u.wr_byte(CMD_SKIP_ID);
        master_u.us(2);
        check(func_active, 1'b1);
        rst_seq();
        master_u.wr_byte(CMD_ALARM_SEARCH);
        rd(1'b1);
        rd(1'b1);
        rst_seq();
        int_enable = 3'h1 << k;
        master_u.us(20);
        alarm();
        q.push_back(1'b0);
        master_u.peek(5);
        check(int_pending, 1'b1);
        check(alarm_flag_status, 8'h01 << k);
        master_u.us(400);
        repeat (4) begin
            strd(STATUS_ADDR ^ (12'h001 + 12'($urandom % 4095)));
            check(int_pending, 1'b1);
        end
        rst_seq();
        master_u.wr_byte(CMD_ALARM_SEARCH);
        rd(ID[0]);
        rd(!ID[0]);
        strd(STATUS_ADDR);
        check(alarm_flag_status, 8'h00);
        check(int_pending, 1'b0);
        alarm();
        q.push_back(1'b1);
        master_u.peek(5);
        check(int_pending, 1'b1);
        int_enable = 3'h0;
        master_u.us(1);
        check(int_pending, 1'b0);
        strd(STATUS_ADDR);
        int_enable = 3'h1 << k;
        q.push_back(1'b0);
        q.push_back(1'b0);
        fork
            master_u.bus_reset();
            begin
                master_u.us(540);
                alarm();
            end
        join
        check(alarm_flag_status, 8'h01 << k);
        check(line_out, 1'b0);
        report_and_stop();
    end
endmodule
